// *** plc_top.sv ***
// plc_top: request labeller with per-partition settings, regulation and monitor.
// assumes: one clock, synchronous reset; requester and downstream on the same
// clock; registers reached over an Avalon-MM slave with waitrequest.
`timescale 1ns/10ps
`default_nettype none
module plc_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [plc_pkg::AVS_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic up_valid,
   output logic up_ready,
   input wire logic [plc_pkg::ADDR_W-1:0] up_addr,
   input wire logic up_write,
   input wire logic up_alloc,
   input wire logic [1:0] up_el,
   input wire logic [1:0] up_sec_state,
   output logic dn_valid,
   input wire logic dn_ready,
   output logic [plc_pkg::ADDR_W-1:0] dn_addr,
   output logic dn_write,
   output logic dn_alloc,
   output logic [plc_pkg::PID_W-1:0] dn_partition_id,
   output logic [plc_pkg::PMG_W-1:0] dn_monitor_group,
   output logic dn_nonsecure_space_bit,
   output logic [plc_pkg::SP_W-1:0] dn_space_selector,
   output logic [plc_pkg::WAY_W-1:0] dn_way_mask,
   output logic [plc_pkg::PRIO_W-1:0] dn_priority,
   input wire logic ev_valid,
   input wire logic [plc_pkg::PID_W-1:0] ev_partition_id,
   input wire logic [plc_pkg::SP_W-1:0] ev_space_selector
);
   // byte-lane merge, used by the setting, map, control, filter and table registers
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : be_merge

   // table index from space and id
   function automatic logic [plc_pkg::IDX_W-1:0] tbl_index(input logic [plc_pkg::SP_W-1:0] sp,
                                                           input logic [plc_pkg::PID_W-1:0] pid);
      return {sp, pid};
   endfunction : tbl_index

   // register state
   logic [31:0] set_el0;
   logic [31:0] set_el1;
   logic [31:0] set_el2;
   logic [31:0] set_el3;
   logic [31:0] vmap0;
   logic [31:0] vmap1;
   logic [31:0] ctrl;
   logic [plc_pkg::IDX_W-1:0] tsel;
   logic [31:0] mfilt;
   logic [31:0] mcnt;
   logic ack;

   // settings tables, one per resource control
   logic [plc_pkg::WAY_W-1:0] way_tbl [plc_pkg::ENTRIES];
   logic [plc_pkg::CAP_W-1:0] cap_tbl [plc_pkg::ENTRIES];
   logic [plc_pkg::PRIO_W-1:0] prio_tbl [plc_pkg::ENTRIES];
   logic [plc_pkg::CAP_W-1:0] usage [plc_pkg::ENTRIES];

   // label of the incoming request
   logic [plc_pkg::PID_W-1:0] lbl_pid;
   logic [plc_pkg::PMG_W-1:0] lbl_pmg;
   logic lbl_ns;
   logic [plc_pkg::SP_W-1:0] lbl_sp;

   plc_label u_label (
      .el(up_el),
      .sec_state(up_sec_state),
      .set_el0(set_el0),
      .set_el1(set_el1),
      .set_el2(set_el2),
      .set_el3(set_el3),
      .vmap({vmap1, vmap0}),
      .virt_en(ctrl[plc_pkg::CTRL_VIRT]),
      .fixed_en(ctrl[plc_pkg::CTRL_FIXED]),
      .fixed_space(ctrl[plc_pkg::CTRL_FSP_LSB +: 2]),
      .partition_id(lbl_pid),
      .monitor_group(lbl_pmg),
      .nonsecure_space_bit(lbl_ns),
      .space_selector(lbl_sp)
   );

   // bus decode
   wire bus_req = avs_read | avs_write;
   wire wr_go = avs_write & ack;
   wire hit_set0 = avs_address == plc_pkg::OFS_SET_EL0;
   wire hit_set1 = avs_address == plc_pkg::OFS_SET_EL1;
   wire hit_set2 = avs_address == plc_pkg::OFS_SET_EL2;
   wire hit_set3 = avs_address == plc_pkg::OFS_SET_EL3;
   wire hit_vm0 = avs_address == plc_pkg::OFS_VMAP0;
   wire hit_vm1 = avs_address == plc_pkg::OFS_VMAP1;
   wire hit_ctrl = avs_address == plc_pkg::OFS_CTRL;
   wire hit_tsel = avs_address == plc_pkg::OFS_TSEL;
   wire hit_tcfg = avs_address == plc_pkg::OFS_TCFG;
   wire hit_tuse = avs_address == plc_pkg::OFS_TUSE;
   wire hit_mfilt = avs_address == plc_pkg::OFS_MFILT;
   wire hit_mcnt = avs_address == plc_pkg::OFS_MCNT;
   wire hit_id = avs_address == plc_pkg::OFS_ID;

   // width report
   // software reads both widths and uses the narrowest in the system
   wire [31:0] id_word = {15'h0000, plc_pkg::REALM_IMPL, 8'(plc_pkg::PMG_W), 8'(plc_pkg::PID_W)};
   wire [31:0] tcfg_word = {14'h0000, prio_tbl[tsel], cap_tbl[tsel], way_tbl[tsel]};
   wire [31:0] tcfg_new = be_merge(tcfg_word, avs_writedata, avs_byteenable);

   // register read mux
   // unmapped offsets read as zero
   wire [31:0] rd_mux = hit_id ? id_word :
                        hit_set0 ? set_el0 :
                        hit_set1 ? set_el1 :
                        hit_set2 ? set_el2 :
                        hit_set3 ? set_el3 :
                        hit_vm0 ? vmap0 :
                        hit_vm1 ? vmap1 :
                        hit_ctrl ? ctrl :
                        hit_tsel ? {26'h0000000, tsel} :
                        hit_tcfg ? tcfg_word :
                        hit_tuse ? {24'h000000, usage[tsel]} :
                        hit_mfilt ? mfilt :
                        hit_mcnt ? mcnt : 32'h0000_0000;

   // one wait cycle per access: data captured first, write lands on the ack edge
   assign avs_waitrequest = bus_req & ~ack;

   // bus acknowledge and read data
   always_ff @(posedge clk) begin
      if (reset) begin
         ack <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack <= bus_req & ~ack;
         if (avs_read & ~ack) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         set_el0 <= plc_pkg::RST_SET;
         set_el1 <= plc_pkg::RST_SET;
         set_el2 <= plc_pkg::RST_SET;
         set_el3 <= plc_pkg::RST_SET;
         vmap0 <= plc_pkg::RST_SET;
         vmap1 <= plc_pkg::RST_SET;
         ctrl <= plc_pkg::RST_CTRL;
         tsel <= '0;
         mfilt <= plc_pkg::RST_SET;
      end else if (wr_go) begin
         if (hit_set0) set_el0 <= be_merge(set_el0, avs_writedata, avs_byteenable);
         if (hit_set1) set_el1 <= be_merge(set_el1, avs_writedata, avs_byteenable);
         if (hit_set2) set_el2 <= be_merge(set_el2, avs_writedata, avs_byteenable);
         if (hit_set3) set_el3 <= be_merge(set_el3, avs_writedata, avs_byteenable);
         if (hit_vm0) vmap0 <= be_merge(vmap0, avs_writedata, avs_byteenable);
         if (hit_vm1) vmap1 <= be_merge(vmap1, avs_writedata, avs_byteenable);
         if (hit_ctrl) ctrl <= be_merge(ctrl, avs_writedata, avs_byteenable);
         if (hit_tsel && avs_byteenable[0]) tsel <= avs_writedata[plc_pkg::IDX_W-1:0];
         if (hit_mfilt) mfilt <= be_merge(mfilt, avs_writedata, avs_byteenable);
      end
   end

   // id and space index
   // the full selector indexes, so root and realm rows stay apart
   wire [plc_pkg::IDX_W-1:0] req_idx = tbl_index(lbl_sp, lbl_pid);
   wire [plc_pkg::IDX_W-1:0] ev_idx = tbl_index(ev_space_selector, ev_partition_id);
   wire accept = up_valid & up_ready;

   // setting of each control for this request
   wire [plc_pkg::CAP_W-1:0] cap_sel = cap_tbl[req_idx];
   wire [plc_pkg::PRIO_W-1:0] prio_sel = prio_tbl[req_idx];
   wire [plc_pkg::CAP_W-1:0] use_sel = usage[req_idx];

   // usage against capacity
   // the limit is ignored while regulation is switched off
   wire cap_ok = ~ctrl[plc_pkg::CTRL_REG_EN] | (use_sel < cap_sel);

   wire [plc_pkg::WAY_W-1:0] way_sel = way_tbl[req_idx];
   wire grant = up_alloc & cap_ok & (way_sel != '0);
   wire [plc_pkg::WAY_W-1:0] way_out = grant ? way_sel : '0;

   // separate tables per control
   // written through the indirect index; one write hits one entry
   wire tcfg_go = wr_go & hit_tcfg;

   // way table
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < plc_pkg::ENTRIES; i++) begin
            way_tbl[i] <= plc_pkg::RST_WAY;
         end
      end else if (tcfg_go) begin
         way_tbl[tsel] <= tcfg_new[plc_pkg::TCFG_WAY_LSB +: plc_pkg::WAY_W];
      end
   end

   // capacity table
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < plc_pkg::ENTRIES; i++) begin
            cap_tbl[i] <= plc_pkg::RST_CAP;
         end
      end else if (tcfg_go) begin
         cap_tbl[tsel] <= tcfg_new[plc_pkg::TCFG_CAP_LSB +: plc_pkg::CAP_W];
      end
   end

   // priority table
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < plc_pkg::ENTRIES; i++) begin
            prio_tbl[i] <= plc_pkg::RST_PRIO;
         end
      end else if (tcfg_go) begin
         prio_tbl[tsel] <= tcfg_new[plc_pkg::TCFG_PRIO_LSB +: plc_pkg::PRIO_W];
      end
   end

   // per-partition usage measurement
   // saturating both ways, so a stray eviction cannot wrap the count
   genvar g;
   generate
      for (g = 0; g < plc_pkg::ENTRIES; g++) begin : g_usage
         wire inc = accept & grant & (req_idx == plc_pkg::IDX_W'(g));
         wire dec = ev_valid & (ev_idx == plc_pkg::IDX_W'(g));
         always_ff @(posedge clk) begin
            if (reset) begin
               usage[g] <= '0;
            end else if (inc && !dec && usage[g] != '1) begin
               usage[g] <= usage[g] + 8'h01;
            end else if (dec && !inc && usage[g] != '0) begin
               usage[g] <= usage[g] - 8'h01;
            end
         end
      end
   endgenerate

   wire mon_hit = mfilt[plc_pkg::MF_EN] &&
                  lbl_pid == mfilt[plc_pkg::MF_PID_LSB +: plc_pkg::PID_W] &&
                  lbl_pmg == mfilt[plc_pkg::MF_PMG_LSB +: plc_pkg::PMG_W] &&
                  lbl_sp == mfilt[plc_pkg::MF_SP_LSB +: plc_pkg::SP_W];
   wire mcnt_clr = wr_go & hit_mcnt;

   // monitor count
   // a match in the clearing cycle is kept: the count restarts at one
   always_ff @(posedge clk) begin
      if (reset) begin
         mcnt <= 32'h0000_0000;
      end else if (mcnt_clr) begin
         mcnt <= {31'h00000000, accept & mon_hit};
      end else if (accept && mon_hit && mcnt != 32'hffff_ffff) begin
         mcnt <= mcnt + 32'h0000_0001;
      end
   end

   // output stage holds request and label together
   // a single stage, ready passes straight through when it drains
   assign up_ready = ~dn_valid | dn_ready;

   // stage occupancy
   always_ff @(posedge clk) begin
      if (reset) begin
         dn_valid <= 1'b0;
      end else if (accept) begin
         dn_valid <= 1'b1;
      end else if (dn_ready) begin
         dn_valid <= 1'b0;
      end
   end

   // address and command untouched by regulation
   always_ff @(posedge clk) begin
      if (reset) begin
         dn_addr <= '0;
         dn_write <= 1'b0;
      end else if (accept) begin
         dn_addr <= up_addr;
         dn_write <= up_write;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dn_partition_id <= '0;
         dn_monitor_group <= '0;
         dn_nonsecure_space_bit <= 1'b0;
         dn_space_selector <= '0;
      end else if (accept) begin
         dn_partition_id <= lbl_pid;
         dn_monitor_group <= lbl_pmg;
         dn_nonsecure_space_bit <= lbl_ns;
         dn_space_selector <= lbl_sp;
      end
   end

   // regulator decision
   // taken at accept, so a later table rewrite cannot alter a waiting request
   always_ff @(posedge clk) begin
      if (reset) begin
         dn_alloc <= 1'b0;
         dn_way_mask <= '0;
         dn_priority <= '0;
      end else if (accept) begin
         dn_alloc <= grant;
         dn_way_mask <= way_out;
         dn_priority <= prio_sel;
      end
   end
endmodule : plc_top
`default_nettype wire

// *** plc_pkg.sv ***
// plc_pkg: shared constants for the partition label and control block.
// assumes: included before every other file of the block; nothing imported.
package plc_pkg;
   // label field widths, shared by every file of this block
   localparam int PID_W = 4;
   localparam int PMG_W = 2;
   localparam int SP_W = 2;
   localparam int IDX_W = SP_W + PID_W;
   localparam int ENTRIES = 64;
   localparam int WAY_W = 8;
   localparam int CAP_W = 8;
   localparam int PRIO_W = 2;
   localparam int ADDR_W = 32;
   localparam int AVS_AW = 8;

   // space selector encodings
   typedef enum logic [1:0] {
      SP_SECURE = 2'h0,
      SP_NONSECURE = 2'h1,
      SP_ROOT = 2'h2,
      SP_REALM = 2'h3
   } plc_space_type;

   // realm extension present: four identifier spaces
   localparam logic REALM_IMPL = 1'b1;

   // register byte offsets
   localparam logic [7:0] OFS_ID = 8'h00;
   localparam logic [7:0] OFS_SET_EL0 = 8'h04;
   localparam logic [7:0] OFS_SET_EL1 = 8'h08;
   localparam logic [7:0] OFS_SET_EL2 = 8'h0c;
   localparam logic [7:0] OFS_SET_EL3 = 8'h10;
   localparam logic [7:0] OFS_VMAP0 = 8'h14;
   localparam logic [7:0] OFS_VMAP1 = 8'h18;
   localparam logic [7:0] OFS_CTRL = 8'h1c;
   localparam logic [7:0] OFS_TSEL = 8'h20;
   localparam logic [7:0] OFS_TCFG = 8'h24;
   localparam logic [7:0] OFS_TUSE = 8'h28;
   localparam logic [7:0] OFS_MFILT = 8'h2c;
   localparam logic [7:0] OFS_MCNT = 8'h30;

   // field positions in setting, control, table and filter words
   localparam int SET_PID_LSB = 0;
   localparam int SET_PMG_LSB = 8;
   localparam int CTRL_VIRT = 0;
   localparam int CTRL_REG_EN = 1;
   localparam int CTRL_FIXED = 2;
   localparam int CTRL_FSP_LSB = 4;
   localparam int TCFG_WAY_LSB = 0;
   localparam int TCFG_CAP_LSB = 8;
   localparam int TCFG_PRIO_LSB = 16;
   localparam int MF_PID_LSB = 0;
   localparam int MF_PMG_LSB = 8;
   localparam int MF_SP_LSB = 12;
   localparam int MF_EN = 16;

   // reset values
   localparam logic [31:0] RST_SET = 32'h0000_0000;
   localparam logic [31:0] RST_CTRL = 32'h0000_0002;
   localparam logic [WAY_W-1:0] RST_WAY = 8'hff;
   localparam logic [CAP_W-1:0] RST_CAP = 8'hff;
   localparam logic [PRIO_W-1:0] RST_PRIO = 2'h0;
endpackage : plc_pkg

// *** plc_label.sv ***
// plc_label: builds the request label from exception level and security state.
// assumes: all inputs come from logic on the same clock; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module plc_label (
   input wire logic [1:0] el,
   input wire logic [1:0] sec_state,
   input wire logic [31:0] set_el0,
   input wire logic [31:0] set_el1,
   input wire logic [31:0] set_el2,
   input wire logic [31:0] set_el3,
   input wire logic [63:0] vmap,
   input wire logic virt_en,
   input wire logic fixed_en,
   input wire logic [1:0] fixed_space,
   output logic [plc_pkg::PID_W-1:0] partition_id,
   output logic [plc_pkg::PMG_W-1:0] monitor_group,
   output logic nonsecure_space_bit,
   output logic [plc_pkg::SP_W-1:0] space_selector
);
   logic [31:0] cur_set;
   logic [plc_pkg::PID_W-1:0] raw_pid;
   logic [plc_pkg::PID_W-1:0] phys_pid;
   logic use_virt;
   logic [1:0] lbl_space;

   // setting register in effect for the current level
   assign cur_set = (el == 2'h0) ? set_el0 : (el == 2'h1) ? set_el1 : (el == 2'h2) ? set_el2 : set_el3;
   assign raw_pid = cur_set[plc_pkg::SET_PID_LSB +: plc_pkg::PID_W];

   // virtual id mapping
   // only user and kernel levels are virtualised, never root state
   assign use_virt = virt_en && (el[1] == 1'b0) && (sec_state != plc_pkg::SP_ROOT);
   assign phys_pid = use_virt ? vmap[raw_pid*plc_pkg::PID_W +: plc_pkg::PID_W] : raw_pid;

   // four space selection
   // without the realm extension only secure/non-secure survive
   assign lbl_space = plc_pkg::REALM_IMPL ? sec_state : {1'b0, sec_state[0]};

   // fixed default labels
   // for requesters that cannot label: default id and group, fixed space
   assign partition_id = fixed_en ? '0 : phys_pid;
   assign monitor_group = fixed_en ? '0 : cur_set[plc_pkg::SET_PMG_LSB +: plc_pkg::PMG_W];
   assign space_selector = fixed_en ? fixed_space : lbl_space;

   // space bit from state
   // non-secure and realm are the odd codes
   assign nonsecure_space_bit = space_selector[0];
endmodule : plc_label
`default_nettype wire

// *** plc_checker.sv ***
// plc_checker: port-level assertions on plc_top, attached by bind.
// assumes: one clock domain, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module plc_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic up_valid,
   input wire logic up_ready,
   input wire logic [plc_pkg::ADDR_W-1:0] up_addr,
   input wire logic up_alloc,
   input wire logic dn_valid,
   input wire logic dn_ready,
   input wire logic [plc_pkg::ADDR_W-1:0] dn_addr,
   input wire logic dn_alloc,
   input wire logic [plc_pkg::PID_W-1:0] dn_partition_id,
   input wire logic dn_nonsecure_space_bit,
   input wire logic [plc_pkg::SP_W-1:0] dn_space_selector,
   input wire logic [plc_pkg::WAY_W-1:0] dn_way_mask
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // accepted request appears downstream one cycle later
   property p_take;
      up_valid && up_ready |=> dn_valid && dn_addr == $past(up_addr);
   endproperty
   a_take: assert property (p_take) else $error("request not forwarded");
   // stalled request keeps address and labels together
   property p_hold;
      dn_valid && !dn_ready |=> dn_valid && $stable({dn_addr, dn_partition_id, dn_space_selector, dn_way_mask});
   endproperty
   a_hold: assert property (p_hold) else $error("stalled request changed");
   // no new request while the stage is blocked
   property p_refuse;
      dn_valid && !dn_ready |-> !up_ready;
   endproperty
   a_refuse: assert property (p_refuse) else $error("ready while blocked");
   // space bit agrees with the selector
   property p_ns;
      dn_valid |-> dn_nonsecure_space_bit == dn_space_selector[0];
   endproperty
   a_ns: assert property (p_ns) else $error("space bit disagrees");
   // granted allocation always names some way
   property p_way;
      dn_valid && dn_alloc |-> dn_way_mask != 8'h00;
   endproperty
   a_way: assert property (p_way) else $error("grant without ways");
   // refused allocation names no way
   property p_nogrant;
      dn_valid && !dn_alloc |-> dn_way_mask == 8'h00;
   endproperty
   a_nogrant: assert property (p_nogrant) else $error("ways without grant");
   // regulation never invents an allocation
   property p_noalloc;
      up_valid && up_ready && !up_alloc |=> !dn_alloc;
   endproperty
   a_noalloc: assert property (p_noalloc) else $error("allocation invented");
   // register access answers after no more than one wait cycle
   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("register wait too long");
endmodule : plc_checker
bind plc_top plc_checker plc_checker_inst (.clk, .reset, .avs_read, .avs_write, .avs_waitrequest, .up_valid,
   .up_ready, .up_addr, .up_alloc, .dn_valid, .dn_ready, .dn_addr, .dn_alloc, .dn_partition_id,
   .dn_nonsecure_space_bit, .dn_space_selector, .dn_way_mask);
`default_nettype wire

// *** plc_sink.sv ***
// plc_sink: downstream completer model that takes labelled requests.
// assumes: shares clock and reset with plc_top; labels arrive packed.
`timescale 1ns/10ps
`default_nettype none
module plc_sink (
   input wire logic clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic dn_valid,
   input wire logic [19:0] lbl,
   output logic dn_ready,
   output logic [19:0] got,
   output logic [7:0] got_n
);
   // ready every cycle, or every other cycle to stall the block
   always_ff @(posedge clk) begin
      if (reset) begin
         dn_ready <= 1'b0;
         got <= 20'h00000;
         got_n <= 8'h00;
      end else begin
         dn_ready <= slow ? ~dn_ready : 1'b1;
         if (dn_valid && dn_ready) begin
            got <= lbl;
            got_n <= got_n + 8'h01;
         end
      end
   end
endmodule : plc_sink
`default_nettype wire

// *** test_partition_label_and_control.sv ***
// test_partition_label_and_control: register and request-path regression.
// assumes: plc_pkg, plc_top, plc_sink and plc_checker compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_partition_label_and_control;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0, avs_write = 1'b0, up_valid = 1'b0, up_write = 1'b0, up_alloc = 1'b0;
   logic [31:0] avs_writedata = 32'h0, up_addr = 32'h0;
   logic [1:0] up_el = 2'h0, up_sec_state = 2'h0, ev_sp = 2'h0;
   logic ev_valid = 1'b0, slow = 1'b0;
   logic [3:0] ev_pid = 4'h0;
   logic [31:0] avs_readdata, dn_addr;
   logic avs_waitrequest, up_ready, dn_valid, dn_ready, dn_alloc, dn_ns, dn_write;
   logic [3:0] dn_pid;
   logic [1:0] dn_grp, dn_sp, dn_prio;
   logic [7:0] dn_way, got_n;
   logic [19:0] got;
   int bad_count = 0;
   int checks_done = 0;
   int sent = 0;
   plc_top plc_top_inst (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .up_valid(up_valid),
      .up_ready(up_ready), .up_addr(up_addr), .up_write(up_write), .up_alloc(up_alloc), .up_el(up_el),
      .up_sec_state(up_sec_state), .dn_valid(dn_valid), .dn_ready(dn_ready), .dn_addr(dn_addr),
      .dn_write(dn_write), .dn_alloc(dn_alloc), .dn_partition_id(dn_pid), .dn_monitor_group(dn_grp),
      .dn_nonsecure_space_bit(dn_ns), .dn_space_selector(dn_sp), .dn_way_mask(dn_way),
      .dn_priority(dn_prio), .ev_valid(ev_valid), .ev_partition_id(ev_pid), .ev_space_selector(ev_sp));
   plc_sink plc_sink_inst (.clk(clk), .reset(reset), .slow(slow), .dn_valid(dn_valid),
      .lbl({dn_pid, dn_grp, dn_ns, dn_sp, dn_alloc, dn_way, dn_prio}), .dn_ready(dn_ready),
      .got(got), .got_n(got_n));
   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   task automatic fail(input string m);
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
   endtask : fail
   task automatic cmp(input logic [31:0] a, input logic [31:0] e);
      checks_done++;
      if (a !== e) begin
         fail($sformatf("got %h want %h", a, e));
      end
   endtask : cmp
   // a hang ends the run rather than the simulator
   task automatic guard(input int n);
      if (n > 50) begin
         fail("wait timeout");
         print_verdict();
      end
   endtask : guard
   // hold the request until waitrequest is seen low at an edge
   task automatic bus(output logic [31:0] d);
      logic w;
      int n;
      n = 0;
      do begin
         @(negedge clk);
         w = avs_waitrequest;
         d = avs_readdata;
         @(posedge clk);
         n++;
         guard(n);
      end while (w);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      bus(d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      avs_address <= a;
      avs_read <= 1'b1;
      bus(d);
      cmp(d, e);
   endtask : rd
   // valid stays up between back-to-back sends; done() drops it
   task automatic send(input logic [1:0] el, input logic [1:0] sec, input logic al);
      logic r;
      int n;
      n = 0;
      up_el <= el;
      up_sec_state <= sec;
      up_alloc <= al;
      up_addr <= up_addr + 32'h40;
      up_write <= ~up_write;
      up_valid <= 1'b1;
      do begin
         @(negedge clk);
         r = up_ready;
         @(posedge clk);
         n++;
         guard(n);
      end while (!r);
      sent++;
   endtask : send
   // only the last label of a burst is compared
   task automatic done(input logic [19:0] e);
      int n;
      n = 0;
      up_valid <= 1'b0;
      do begin
         @(negedge clk);
         n++;
         guard(n);
      end while (got_n !== 8'(sent));
      cmp({12'h0, got}, {12'h0, e});
      cmp(dn_addr, up_addr);
      cmp({31'h0, dn_write}, {31'h0, up_write});
      @(posedge clk);
   endtask : done
   function automatic logic [19:0] lbl(input logic [3:0] p, input logic [1:0] g, input logic [1:0] s,
                                        input logic a, input logic [7:0] w, input logic [1:0] q);
      return {p, g, s[0], s, a, w, q};
   endfunction : lbl
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // reset values, read-only and unmapped places
      rd(8'h00, 32'h0001_0204);
      rd(8'h1c, 32'h0000_0002);
      rd(8'h24, 32'h0000_ffff);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0001_0204);
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40, 32'h0);
      // each level picks its own setting; every security state
      for (int i = 0; i < 4; i++) begin
         wr(8'h04 + 8'(4 * i), {22'h0, 2'(i), 4'h0, 4'(4 + i)});
         send(2'(i), 2'(i), 1'b0);
         done(lbl(4'(4 + i), 2'(i), 2'(i), 1'b0, 8'h00, 2'h0));
      end
      // virtual map applies to levels 0 and 1 only
      wr(8'h14, 32'h00a0_0000);
      wr(8'h1c, 32'h0000_0003);
      send(2'h1, 2'h1, 1'b0);
      done(lbl(4'ha, 2'h1, 2'h1, 1'b0, 8'h00, 2'h0));
      send(2'h2, 2'h1, 1'b0);
      done(lbl(4'h6, 2'h2, 2'h1, 1'b0, 8'h00, 2'h0));
      // fixed labels for an unlabelled requester
      wr(8'h1c, 32'h0000_0026);
      send(2'h3, 2'h3, 1'b0);
      done(lbl(4'h0, 2'h0, 2'h2, 1'b0, 8'h00, 2'h0));
      wr(8'h1c, 32'h0000_0002);
      // entry {non-secure, 7}: four ways, capacity 2, priority 3; far side stalls
      wr(8'h20, 32'h0000_0017);
      wr(8'h24, 32'h0003_020f);
      rd(8'h24, 32'h0003_020f);
      slow <= 1'b1;
      send(2'h3, 2'h1, 1'b1);
      done(lbl(4'h7, 2'h3, 2'h1, 1'b1, 8'h0f, 2'h3));
      send(2'h3, 2'h1, 1'b1);
      send(2'h3, 2'h1, 1'b1);
      done(lbl(4'h7, 2'h3, 2'h1, 1'b0, 8'h00, 2'h3));
      rd(8'h28, 32'h0000_0002);
      ev_pid <= 4'h7;
      ev_sp <= 2'h1;
      ev_valid <= 1'b1;
      @(posedge clk);
      ev_valid <= 1'b0;
      @(posedge clk);
      rd(8'h28, 32'h0000_0001);
      send(2'h3, 2'h1, 1'b1);
      done(lbl(4'h7, 2'h3, 2'h1, 1'b1, 8'h0f, 2'h3));
      send(2'h3, 2'h0, 1'b1);
      done(lbl(4'h7, 2'h3, 2'h0, 1'b1, 8'hff, 2'h0));
      wr(8'h24, 32'h0003_ff00);
      send(2'h3, 2'h1, 1'b1);
      done(lbl(4'h7, 2'h3, 2'h1, 1'b0, 8'h00, 2'h3));
      slow <= 1'b0;
      // usage monitor filtered by id, group and space
      wr(8'h2c, 32'h0001_1307);
      wr(8'h30, 32'h0);
      send(2'h3, 2'h1, 1'b0);
      send(2'h3, 2'h1, 1'b0);
      send(2'h3, 2'h0, 1'b0);
      done(lbl(4'h7, 2'h3, 2'h0, 1'b0, 8'h00, 2'h0));
      rd(8'h30, 32'h0000_0002);
      wr(8'h30, 32'h0);
      rd(8'h30, 32'h0);
      print_verdict();
   end
endmodule : test_partition_label_and_control
`default_nettype wire
